// ### design/tctl_pkg.sv
// Package for the two-channel transfer control block: register offsets,
// direction codes, fixed memory addresses, reset values and carrier types.
// Assumes a single 20 MHz engine clock shared by the register window and engine.
package tctl_pkg;

   // Register offsets inside the host register window (byte addresses).
   localparam logic [15:0] OFF_SCRATCH = 16'h0000;
   localparam logic [15:0] OFF_SWITCH = 16'h0090;
   localparam logic [15:0] OFF_LED = 16'h00A0;
   localparam logic [15:0] OFF_DIR = 16'h8008;
   localparam logic [15:0] OFF_HOSTBASE = 16'h8028;
   localparam logic [15:0] OFF_CH0 = 16'h8100;
   localparam logic [15:0] OFF_CH1 = 16'h8108;

   // Direction register codes.
   localparam logic [31:0] CODE_HOST_TO_DDR = 32'h11AA0001;
   localparam logic [31:0] CODE_DDR_TO_HOST = 32'h11AA0002;
   localparam logic [31:0] CODE_BLOCK_TO_DDR = 32'h11AA0003;
   localparam logic [31:0] CODE_DDR_TO_BLOCK = 32'h11AA0004;
   localparam logic [31:0] CODE_HOST_TO_BLOCK = 32'h11AA0005;
   localparam logic [31:0] CODE_BLOCK_TO_HOST = 32'h11AA0006;
   localparam logic [31:0] CODE_ENGINE_RESET = 32'h11AA0007;

   // Fixed addresses used by the engine for non-host memories.
   localparam logic [31:0] DDR_SRC_ADDR = 32'h01000000;
   localparam logic [31:0] DDR_DST_ADDR = 32'h00000000;
   localparam logic [31:0] BLOCK_ADDR = 32'h00000000;

   // Status word layout and switch width.
   localparam int DONE_BIT = 31;
   localparam int COUNT_W = 16;
   localparam int SWITCH_W = 8;

   // Values after reset.
   localparam logic [31:0] SCRATCH_RST = 32'h00000000;
   localparam logic [31:0] LED_RST = 32'h00000000;
   localparam logic [31:0] HOSTBASE_RST = 32'h00000000;
   localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;

   typedef enum logic [1:0] {
      TCTL_SPACE_HOST = 2'h0,
      TCTL_SPACE_DDR = 2'h1,
      TCTL_SPACE_BLOCK = 2'h2
   } tctl_space_e;

   // Gray codes along idle, busy, done.
   typedef enum logic [1:0] {
      TCTL_CH_IDLE = 2'h0,
      TCTL_CH_BUSY = 2'h1,
      TCTL_CH_DONE = 2'h3
   } tctl_chan_e;

   typedef struct packed {
      tctl_space_e srcSpace;
      tctl_space_e dstSpace;
      logic [31:0] srcAddr;
      logic [31:0] dstAddr;
   } tctl_desc_s;

   typedef struct packed {
      logic valid;
      logic chan;
      tctl_space_e srcSpace;
      tctl_space_e dstSpace;
   } tctl_start_s;

   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [15:0] addr;
      logic [31:0] wrData;
   } tctl_bar_req_s;

endpackage

// ### design/tctl_two_channel.sv
// Control and status front end of the two-channel transfer engine.
// Assumes register accesses arrive as one-cycle strobes from the host window
// logic on clk, and that the engine's done inputs are on clk as well.
// Operation
// - Codes 1 and 2 start host-to-DDR and DDR-to-host transfers.
// - Codes 3 and 4 start block-memory-to-DDR and DDR-to-block-memory transfers.
// - Codes 5 and 6 start host-to-block-memory and block-memory-to-host transfers.
// - Code 7 resets the engine and starts nothing.
// - Opposite codes written back to back run concurrently on both channels.
// - Status bit 31 is one when the channel has completed.
// - Status bits 15 to 0 give the channel's clock count.
// - Host buffer base register supplies the host memory address.
// - DDR transfers use source 0x0100_0000 and destination 0x0000_0000.
// - All registers sit in the host memory window.
// - Scratchpad at offset zero reads back the last written value.
// - Scratchpad is a full 32-bit read-write word.
`timescale 1ns/10ps
module tctl_two_channel (
   input wire logic clk,
   input wire logic rst,
   input tctl_pkg::tctl_bar_req_s barReq,
   output logic [31:0] barRdData,
   output logic barRdValid,
   input wire logic [tctl_pkg::SWITCH_W-1:0] switchPin,
   output logic [31:0] ledOut,
   output logic engineReset,
   output logic [1:0] chStart,
   output tctl_pkg::tctl_desc_s [1:0] chDesc,
   input wire logic [1:0] chDone
);

   // Odd codes go to channel 0 and even codes to channel 1, so each opposite pair
   // lands on different channels and can overlap.
   function automatic tctl_pkg::tctl_start_s decodeDir(input logic [31:0] code);
      tctl_pkg::tctl_start_s d;
      d = '{valid: 1'b1, chan: 1'b0, srcSpace: tctl_pkg::TCTL_SPACE_HOST,
            dstSpace: tctl_pkg::TCTL_SPACE_DDR};
      unique case (code)
         tctl_pkg::CODE_HOST_TO_DDR: ;
         tctl_pkg::CODE_DDR_TO_HOST: begin
            d.chan = 1'b1;
            d.srcSpace = tctl_pkg::TCTL_SPACE_DDR;
            d.dstSpace = tctl_pkg::TCTL_SPACE_HOST;
         end
         tctl_pkg::CODE_BLOCK_TO_DDR: d.srcSpace = tctl_pkg::TCTL_SPACE_BLOCK;
         tctl_pkg::CODE_DDR_TO_BLOCK: begin
            d.chan = 1'b1;
            d.srcSpace = tctl_pkg::TCTL_SPACE_DDR;
            d.dstSpace = tctl_pkg::TCTL_SPACE_BLOCK;
         end
         tctl_pkg::CODE_HOST_TO_BLOCK: d.dstSpace = tctl_pkg::TCTL_SPACE_BLOCK;
         tctl_pkg::CODE_BLOCK_TO_HOST: begin
            d.chan = 1'b1;
            d.srcSpace = tctl_pkg::TCTL_SPACE_BLOCK;
            d.dstSpace = tctl_pkg::TCTL_SPACE_HOST;
         end
         default: d.valid = 1'b0;
      endcase
      return d;
   endfunction

   // Address the engine uses for one side of a transfer.
   function automatic logic [31:0] spaceAddr(input tctl_pkg::tctl_space_e sp,
                                             input logic isSrc,
                                             input logic [31:0] hostBase);
      logic [31:0] a;
      a = tctl_pkg::BLOCK_ADDR;
      if (sp == tctl_pkg::TCTL_SPACE_HOST) begin
         a = hostBase;
      end else if (sp == tctl_pkg::TCTL_SPACE_DDR) begin
         a = isSrc ? tctl_pkg::DDR_SRC_ADDR : tctl_pkg::DDR_DST_ADDR;
      end
      return a;
   endfunction

   // Status word: completion in the top bit, cycle count in the low half.
   function automatic logic [31:0] statusWord(input tctl_pkg::tctl_chan_e st,
                                              input logic [tctl_pkg::COUNT_W-1:0] cnt);
      logic [31:0] w;
      w = 32'h00000000;
      w[tctl_pkg::DONE_BIT] = (st == tctl_pkg::TCTL_CH_DONE);
      w[tctl_pkg::COUNT_W-1:0] = cnt;
      return w;
   endfunction

   logic [31:0] scratch_r;
   logic [31:0] led_r;
   logic [31:0] hostBase_r;
   logic [tctl_pkg::SWITCH_W-1:0] swMeta_r;
   logic [tctl_pkg::SWITCH_W-1:0] swSync_r;
   tctl_pkg::tctl_chan_e [1:0] chState_r;
   tctl_pkg::tctl_chan_e [1:0] chState_nxt;
   logic [1:0][tctl_pkg::COUNT_W-1:0] count_r;
   logic [1:0][tctl_pkg::COUNT_W-1:0] count_nxt;
   wire tctl_pkg::tctl_desc_s descNew;

   // Register window decode.
   wire wrScratch = barReq.wrEn && (barReq.addr == tctl_pkg::OFF_SCRATCH);
   wire wrLed = barReq.wrEn && (barReq.addr == tctl_pkg::OFF_LED);
   wire wrHostBase = barReq.wrEn && (barReq.addr == tctl_pkg::OFF_HOSTBASE);
   wire wrDir = barReq.wrEn && (barReq.addr == tctl_pkg::OFF_DIR);
   wire tctl_pkg::tctl_start_s dirDec = decodeDir(barReq.wrData);
   wire engReset = wrDir && (barReq.wrData == tctl_pkg::CODE_ENGINE_RESET);
   wire [1:0] startReq;

   // A start on a busy channel is ignored so a running count is never torn.
   genvar c;
   for (c = 0; c < 2; c++) begin : g_chan
      assign startReq[c] = wrDir && dirDec.valid && (dirDec.chan == 1'(c))
                           && (chState_r[c] != tctl_pkg::TCTL_CH_BUSY);
   end

   // Descriptor shared by whichever channel takes the start.
   assign descNew.srcSpace = dirDec.srcSpace;
   assign descNew.dstSpace = dirDec.dstSpace;
   assign descNew.srcAddr = spaceAddr(dirDec.srcSpace, 1'b1, hostBase_r);
   assign descNew.dstAddr = spaceAddr(dirDec.dstSpace, 1'b0, hostBase_r);

   // Channel state and count; engine reset outranks a start and a completion.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         chState_nxt[i] = chState_r[i];
         count_nxt[i] = count_r[i];
         if (engReset) begin
            chState_nxt[i] = tctl_pkg::TCTL_CH_IDLE;
            count_nxt[i] = tctl_pkg::COUNT_RST;
         end else if (startReq[i]) begin
            chState_nxt[i] = tctl_pkg::TCTL_CH_BUSY;
            count_nxt[i] = tctl_pkg::COUNT_RST;
         end else if (chState_r[i] == tctl_pkg::TCTL_CH_BUSY) begin
            count_nxt[i] = count_r[i] + 16'h0001;
            if (chDone[i]) begin
               chState_nxt[i] = tctl_pkg::TCTL_CH_DONE;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         chState_r <= '{tctl_pkg::TCTL_CH_IDLE, tctl_pkg::TCTL_CH_IDLE};
         count_r <= {2{tctl_pkg::COUNT_RST}};
         chStart <= 2'h0;
         engineReset <= 1'b0;
      end else begin
         chState_r <= chState_nxt;
         count_r <= count_nxt;
         chStart <= startReq;
         engineReset <= engReset;
      end
   end

   // Descriptors hold their value between starts for the engine to sample.
   always_ff @(posedge clk) begin
      if (rst) begin
         chDesc <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (startReq[i]) begin
               chDesc[i] <= descNew;
            end
         end
      end
   end

   // Software-written storage.
   always_ff @(posedge clk) begin
      if (rst) begin
         scratch_r <= tctl_pkg::SCRATCH_RST;
         led_r <= tctl_pkg::LED_RST;
         hostBase_r <= tctl_pkg::HOSTBASE_RST;
      end else begin
         if (wrScratch) scratch_r <= barReq.wrData;
         if (wrLed) led_r <= barReq.wrData;
         if (wrHostBase) hostBase_r <= barReq.wrData;
      end
   end
   assign ledOut = led_r;

   // Switches are asynchronous pins; only the second stage is read.
   always_ff @(posedge clk) begin
      swMeta_r <= switchPin;
      swSync_r <= swMeta_r;
   end

   // Read mux; the direction register and unmapped addresses read as zero.
   wire [31:0] rdMux =
      (barReq.addr == tctl_pkg::OFF_SCRATCH) ? scratch_r :
      (barReq.addr == tctl_pkg::OFF_SWITCH) ? {24'h000000, swSync_r} :
      (barReq.addr == tctl_pkg::OFF_LED) ? led_r :
      (barReq.addr == tctl_pkg::OFF_HOSTBASE) ? hostBase_r :
      (barReq.addr == tctl_pkg::OFF_CH0) ? statusWord(chState_r[0], count_r[0]) :
      (barReq.addr == tctl_pkg::OFF_CH1) ? statusWord(chState_r[1], count_r[1]) :
      32'h00000000;

   always_ff @(posedge clk) begin
      if (rst) begin
         barRdData <= 32'h00000000;
         barRdValid <= 1'b0;
      end else begin
         barRdValid <= barReq.rdEn;
         if (barReq.rdEn) barRdData <= rdMux;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_host_to_ddr;
      wrDir && barReq.wrData == tctl_pkg::CODE_HOST_TO_DDR
      && chState_r[0] != tctl_pkg::TCTL_CH_BUSY
      |=> chStart[0] && chDesc[0].srcAddr == $past(hostBase_r)
          && chDesc[0].dstAddr == tctl_pkg::DDR_DST_ADDR;
   endproperty
   a_host_to_ddr: assert property (p_host_to_ddr) else $error("host to DDR start wrong");

   property p_ddr_to_host;
      wrDir && barReq.wrData == tctl_pkg::CODE_DDR_TO_HOST
      && chState_r[1] != tctl_pkg::TCTL_CH_BUSY
      |=> chStart[1] && chDesc[1].srcAddr == tctl_pkg::DDR_SRC_ADDR
          && chDesc[1].dstSpace == tctl_pkg::TCTL_SPACE_HOST;
   endproperty
   a_ddr_to_host: assert property (p_ddr_to_host) else $error("DDR to host start wrong");

   property p_block_ddr;
      startReq[0] && barReq.wrData == tctl_pkg::CODE_BLOCK_TO_DDR
      |=> chDesc[0].srcSpace == tctl_pkg::TCTL_SPACE_BLOCK
          && chDesc[0].dstSpace == tctl_pkg::TCTL_SPACE_DDR;
   endproperty
   a_block_ddr: assert property (p_block_ddr) else $error("block to DDR wrong");

   property p_block_host;
      startReq[1] && barReq.wrData == tctl_pkg::CODE_BLOCK_TO_HOST
      |=> chDesc[1].dstAddr == $past(hostBase_r)
          && chDesc[1].srcSpace == tctl_pkg::TCTL_SPACE_BLOCK;
   endproperty
   a_block_host: assert property (p_block_host) else $error("block to host wrong");

   property p_engine_reset;
      engReset |=> engineReset && chStart == 2'h0 && count_r[0] == tctl_pkg::COUNT_RST
                   && chState_r[1] == tctl_pkg::TCTL_CH_IDLE;
   endproperty
   a_engine_reset: assert property (p_engine_reset) else $error("engine reset wrong");

   property p_concurrent;
      startReq[0] ##1 (startReq[1] && !engReset) |=> chState_r[1] == tctl_pkg::TCTL_CH_BUSY
                                                     && chState_r[0] != tctl_pkg::TCTL_CH_IDLE;
   endproperty
   a_concurrent: assert property (p_concurrent) else $error("channels not concurrent");

   property p_done_bit;
      barReq.rdEn && barReq.addr == tctl_pkg::OFF_CH0
      |=> barRdValid && barRdData[31] == ($past(chState_r[0]) == tctl_pkg::TCTL_CH_DONE);
   endproperty
   a_done_bit: assert property (p_done_bit) else $error("done bit wrong");

   property p_count_run;
      chState_r[0] == tctl_pkg::TCTL_CH_BUSY && !engReset && !startReq[0]
      |=> count_r[0] == $past(count_r[0]) + 16'h0001;
   endproperty
   a_count_run: assert property (p_count_run) else $error("count not running");

   property p_count_hold;
      chState_r[1] == tctl_pkg::TCTL_CH_DONE && !engReset && !startReq[1] |=> $stable(count_r[1]);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("count not held");

   property p_scratch;
      (wrScratch && !barReq.rdEn) ##1 (barReq.rdEn && !barReq.wrEn
                                       && barReq.addr == tctl_pkg::OFF_SCRATCH)
      |=> barRdData == $past(barReq.wrData, 2);
   endproperty
   a_scratch: assert property (p_scratch) else $error("scratchpad readback wrong");

endmodule // tctl_two_channel

// ### dv/tctl_engine_model.sv
// Stand-in for the transfer engine behind the control block.
// Assumes start and reset pulses arrive from the control block on the same clock.
`timescale 1ns/10ps
module tctl_engine_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic engineReset,
   input wire logic [1:0] chStart,
   input wire logic [15:0] lat0,
   input wire logic [15:0] lat1,
   output logic [1:0] chDone
);
   logic [15:0] left_r [2];
   // Completion is a one-cycle pulse, so a block that waits for a level would hang.
   assign chDone = {left_r[1] == 16'h0001, left_r[0] == 16'h0001};
   // Each channel counts down from the latency that the bench picked.
   always_ff @(posedge clk) begin
      for (int c = 0; c < 2; c++) begin
         if (rst || engineReset) begin
            left_r[c] <= 16'h0000;
         end else if (chStart[c]) begin
            left_r[c] <= (c == 0) ? lat0 : lat1;
         end else if (left_r[c] != 16'h0000) begin
            left_r[c] <= left_r[c] - 16'h0001;
         end
      end
   end
endmodule // tctl_engine_model

// ### dv/tctl_two_channel_tb_top.sv
// Self-checking bench for the two-channel transfer control block.
// Assumes the engine stand-in answers starts; inputs move on the falling edge.
`timescale 1ns/10ps
module tctl_two_channel_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   tctl_pkg::tctl_bar_req_s barReq = '0;
   logic [31:0] barRdData;
   logic [31:0] ledOut;
   logic barRdValid;
   logic engineReset;
   logic [7:0] switchPin = 8'h3C;
   logic [1:0] chStart;
   logic [1:0] chDone;
   tctl_pkg::tctl_desc_s [1:0] chDesc;
   logic [15:0] lat0 = 16'h0004;
   logic [15:0] lat1 = 16'h0004;
   logic [31:0] hostBase = 32'h12345678;
   logic [31:0] s;
   logic [67:0] ex;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [1:0] srcSp [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h2};
   logic [1:0] dstSp [6] = '{2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0};

   tctl_two_channel i_tctl_two_channel (.clk(clk), .rst(rst), .barReq(barReq),
      .barRdData(barRdData), .barRdValid(barRdValid), .switchPin(switchPin),
      .ledOut(ledOut), .engineReset(engineReset), .chStart(chStart),
      .chDesc(chDesc), .chDone(chDone));
   tctl_engine_model i_tctl_engine_model (.clk(clk), .rst(rst), .engineReset(engineReset),
      .chStart(chStart), .lat0(lat0), .lat1(lat1), .chDone(chDone));

   // Clock and a ceiling on run length, far above what the scenarios need.
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end

   task automatic check(input string n, input logic [67:0] seen, input logic [67:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Bus tasks start one falling edge late, so strobes never toggle twice in a step.
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(negedge clk);
      barReq.rdEn = 1'b1;
      barReq.addr = a;
      @(negedge clk);
      barReq.rdEn = 1'b0;
      check("readValid", 68'(barRdValid), 68'h1);
      d = barRdData;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge clk);
      barReq.wrEn = 1'b1;
      barReq.addr = a;
      barReq.wrData = d;
      @(negedge clk);
      barReq.wrEn = 1'b0;
   endtask

   task automatic waitDone(input int ch, output logic [31:0] st);
      st = '0;
      for (int i = 0; i < 100 && st[31] !== 1'b1; i++) begin
         rd(ch ? tctl_pkg::OFF_CH1 : tctl_pkg::OFF_CH0, st);
      end
   endtask

   function automatic logic [31:0] addrOf(input logic [1:0] sp, input logic isSrc);
      if (sp == 2'h0) return hostBase;
      if (sp == 2'h1) return isSrc ? tctl_pkg::DDR_SRC_ADDR : tctl_pkg::DDR_DST_ADDR;
      return tctl_pkg::BLOCK_ADDR;
   endfunction

   task automatic t_reset_values();
      logic [15:0] offs [7];
      offs = '{tctl_pkg::OFF_SCRATCH, tctl_pkg::OFF_LED, tctl_pkg::OFF_HOSTBASE,
         tctl_pkg::OFF_CH0, tctl_pkg::OFF_CH1, tctl_pkg::OFF_DIR, 16'h0004};
      check("ledOut", 68'(ledOut), 68'h0);
      foreach (offs[i]) begin
         rd(offs[i], s);
         check("resetRead", 68'(s), 68'h0);
      end
   endtask

   task automatic t_regs();
      wr(tctl_pkg::OFF_SCRATCH, 32'hA5A5F00F);
      rd(tctl_pkg::OFF_SCRATCH, s);
      check("scratch", 68'(s), 68'hA5A5F00F);
      wr(tctl_pkg::OFF_SCRATCH, 32'h5A5A0FF0);
      rd(tctl_pkg::OFF_SCRATCH, s);
      check("scratch", 68'(s), 68'h5A5A0FF0);
      // A read straight after a write must already see the new word.
      @(negedge clk);
      barReq.wrEn = 1'b1;
      barReq.addr = tctl_pkg::OFF_SCRATCH;
      barReq.wrData = 32'h0F1E2D3C;
      @(negedge clk);
      barReq.wrEn = 1'b0;
      barReq.rdEn = 1'b1;
      @(negedge clk);
      barReq.rdEn = 1'b0;
      check("scratchNext", 68'(barRdData), 68'h0F1E2D3C);
      wr(tctl_pkg::OFF_LED, 32'h0000005A);
      check("ledOut", 68'(ledOut), 68'h5A);
      wr(tctl_pkg::OFF_SWITCH, 32'hFFFFFFFF);
      rd(tctl_pkg::OFF_SWITCH, s);
      check("switch", 68'(s), 68'h3C);
      wr(tctl_pkg::OFF_HOSTBASE, hostBase);
      rd(tctl_pkg::OFF_HOSTBASE, s);
      check("hostBase", 68'(s), 68'(hostBase));
   endtask

   // Every direction code once, each with its own latency, after the engine reset.
   task automatic t_codes();
      int ch;
      wr(tctl_pkg::OFF_DIR, tctl_pkg::CODE_ENGINE_RESET);
      check("engineReset", 68'(engineReset), 68'h1);
      check("chStart", 68'(chStart), 68'h0);
      for (int k = 1; k <= 6; k++) begin
         ch = (k % 2 == 1) ? 0 : 1;
         lat0 = 16'(3 * k);
         lat1 = 16'(3 * k);
         wr(tctl_pkg::OFF_DIR, tctl_pkg::CODE_HOST_TO_DDR + 32'(k - 1));
         ex = {srcSp[k-1], dstSp[k-1], addrOf(srcSp[k-1], 1'b1), addrOf(dstSp[k-1], 1'b0)};
         check("chStart", 68'(chStart), 68'(2'b01 << ch));
         check("chDesc", 68'(chDesc[ch]), ex);
         rd(ch ? tctl_pkg::OFF_CH1 : tctl_pkg::OFF_CH0, s);
         check("busyFlag", 68'(s[31]), 68'h0);
         waitDone(ch, s);
         check("status", 68'(s), {36'h0, 1'b1, 15'h0, 16'(3 * k + 1)});
         repeat (5) @(negedge clk);
         rd(ch ? tctl_pkg::OFF_CH1 : tctl_pkg::OFF_CH0, s);
         check("held", 68'(s), {36'h0, 1'b1, 15'h0, 16'(3 * k + 1)});
      end
   endtask

   // Opposite codes written on consecutive cycles run on both channels at once.
   task automatic t_concurrent();
      lat0 = 16'h0005;
      lat1 = 16'h0009;
      @(negedge clk);
      barReq.wrEn = 1'b1;
      barReq.addr = tctl_pkg::OFF_DIR;
      barReq.wrData = tctl_pkg::CODE_HOST_TO_DDR;
      @(negedge clk);
      barReq.wrData = tctl_pkg::CODE_DDR_TO_HOST;
      check("chStart", 68'(chStart), 68'h1);
      @(negedge clk);
      barReq.wrEn = 1'b0;
      check("chStart", 68'(chStart), 68'h2);
      waitDone(1, s);
      check("ch1", 68'(s), {36'h0, 1'b1, 15'h0, 16'h000A});
      rd(tctl_pkg::OFF_CH0, s);
      check("ch0", 68'(s), {36'h0, 1'b1, 15'h0, 16'h0006});
   endtask

   // A start to a busy channel is ignored; the reset code clears a busy channel.
   task automatic t_busy_reset();
      lat0 = 16'h0028;
      wr(tctl_pkg::OFF_DIR, tctl_pkg::CODE_HOST_TO_BLOCK);
      wr(tctl_pkg::OFF_DIR, tctl_pkg::CODE_BLOCK_TO_DDR);
      check("chStart", 68'(chStart), 68'h0);
      check("chDescHeld", 68'(chDesc[0]), {2'h0, 2'h2, hostBase, tctl_pkg::BLOCK_ADDR});
      wr(tctl_pkg::OFF_DIR, tctl_pkg::CODE_ENGINE_RESET);
      check("engineReset", 68'(engineReset), 68'h1);
      repeat (50) @(negedge clk);
      rd(tctl_pkg::OFF_CH0, s);
      check("cleared", 68'(s), 68'h0);
      lat0 = 16'h0002;
      wr(tctl_pkg::OFF_DIR, tctl_pkg::CODE_HOST_TO_DDR);
      waitDone(0, s);
      check("restart", 68'(s), {36'h0, 1'b1, 15'h0, 16'h0003});
   endtask

   // Reset, then the scenarios in turn, then the verdict.
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      t_reset_values();
      t_regs();
      t_codes();
      t_concurrent();
      t_busy_reset();
      conclude();
   end
endmodule // tctl_two_channel_tb_top
